// >>> inc/xym_consts.svh
`ifndef XYM_CONSTS_SVH
`define XYM_CONSTS_SVH

// Instruction word layout, bit 15 is the most significant
`define XYM_PREFIX      6'h3c
`define XYM_PREFIX_HI   15
`define XYM_PREFIX_LO   10
`define XYM_XPTR_BIT    9
`define XYM_YPTR_BIT    8
`define XYM_XREG_BIT    7
`define XYM_YREG_BIT    6
`define XYM_XDIR_BIT    5
`define XYM_YDIR_BIT    4
`define XYM_XMODE_HI    3
`define XYM_XMODE_LO    2
`define XYM_YMODE_HI    1
`define XYM_YMODE_LO    0

// Datapath
`define XYM_PTR_STEP    32'h00000002
`define XYM_REG_RST     32'h00000000
`define XYM_WORD_RST    16'h0000
`define XYM_LOWER_ZERO  16'h0000
`define XYM_UPPER_HI    31
`define XYM_UPPER_LO    16

`endif

// >>> inc/xym_pkg.sv
package xym_pkg;

	// Pointer post-update selected by a two-bit mode field
	typedef enum logic [1:0] {
		XYM_MODE_NONE  = 2'h0,
		XYM_MODE_KEEP  = 2'h1,
		XYM_MODE_INC   = 2'h2,
		XYM_MODE_INDEX = 2'h3
	} xym_mode_t;

	typedef logic [31:0] xym_reg_t;
	typedef logic [15:0] xym_word_t;

endpackage

// >>> hw/xym_mem_port.sv
`timescale 1ns/1ns
`include "xym_consts.svh"

// One memory side: registers the word request and tracks the load return.
module xym_mem_port (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             issue,
	input  wire logic             store,
	input  wire logic             src_sel,
	input  wire logic             dst_sel,
	input  wire xym_pkg::xym_reg_t ptr_val,
	input  wire xym_pkg::xym_reg_t acc_0,
	input  wire xym_pkg::xym_reg_t acc_1,
	output logic                  mem_req,
	output logic                  mem_we,
	output xym_pkg::xym_reg_t     mem_addr,
	output xym_pkg::xym_word_t    mem_wdata,
	output logic                  wb_valid,
	output logic                  wb_sel
);

	logic               req_q, req_d;
	logic               we_q, we_d;
	xym_pkg::xym_reg_t  addr_q, addr_d;
	xym_pkg::xym_word_t wdata_q, wdata_d;
	logic               ld1_q, ld1_d;
	logic               sel1_q, sel1_d;
	logic               ld2_q, ld2_d;
	logic               sel2_q, sel2_d;
	xym_pkg::xym_reg_t  src;

	always_comb begin
		src     = src_sel ? acc_1 : acc_0;
		req_d   = issue;
		we_d    = issue & store;
		addr_d  = issue ? ptr_val : addr_q;
		// Only the upper half of the accumulator leaves, one word wide
		wdata_d = (issue & store) ? src[`XYM_UPPER_HI:`XYM_UPPER_LO] : wdata_q;
		// Memory answers in the cycle after the request, so two stages
		ld1_d   = issue & ~store;
		sel1_d  = issue ? dst_sel : sel1_q;
		ld2_d   = ld1_q;
		sel2_d  = sel1_q;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_q   <= 1'b0;
			we_q    <= 1'b0;
			addr_q  <= `XYM_REG_RST;
			wdata_q <= `XYM_WORD_RST;
			ld1_q   <= 1'b0;
			sel1_q  <= 1'b0;
			ld2_q   <= 1'b0;
			sel2_q  <= 1'b0;
		end else if (ce) begin
			req_q   <= req_d;
			we_q    <= we_d;
			addr_q  <= addr_d;
			wdata_q <= wdata_d;
			ld1_q   <= ld1_d;
			sel1_q  <= sel1_d;
			ld2_q   <= ld2_d;
			sel2_q  <= sel2_d;
		end
	end

	assign mem_req   = req_q;
	assign mem_we    = we_q;
	assign mem_addr  = addr_q;
	assign mem_wdata = wdata_q;
	assign wb_valid  = ld2_q;
	assign wb_sel    = sel2_q;

endmodule

// >>> hw/xym_move_unit.sv
// Contract
// - Every X-side access is one 16-bit word, with no byte or longword size.
// - Every Y-side access is one 16-bit word, with no byte or longword size.
// - A load writes the fetched word to the upper half of the destination and zeroes the lower half.
// - A store writes only the upper 16 bits of the selected accumulator to memory.
// - The bits that the X move leaves free carry the Y move fields in the same word.
// - The bits that the Y move leaves free carry the X move fields, both decoded independently.
// - X mode 01 keeps the X pointer, 10 adds 2 to it after the access.
// - X direction 1 stores from the accumulator, 0 loads, and X mode 11 adds the X index after the access.
// - Y mode 01 keeps the Y pointer, 10 adds 2 after the access, and the Y direction bit picks load or store.
// - Y mode 11 adds the Y index to the Y pointer after the access.
// - X mode 00 performs no X access and changes nothing on the X path.
// - Y mode 00 performs no Y access and changes nothing on the Y path.
// - X pointer select picks R4 or R5, load target X0 or X1, store source A0 or A1.
// - Y pointer select picks R6 or R7, load target Y0 or Y1, store source A0 or A1.
`timescale 1ns/1ns
`include "xym_consts.svh"

module xym_move_unit (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             insn_valid,
	input  wire logic [15:0]      insn,
	input  wire xym_pkg::xym_reg_t x_index,
	input  wire xym_pkg::xym_reg_t y_index,
	input  wire xym_pkg::xym_reg_t accumulator_0,
	input  wire xym_pkg::xym_reg_t accumulator_1,
	input  wire xym_pkg::xym_word_t x_mem_rdata,
	input  wire xym_pkg::xym_word_t y_mem_rdata,
	output xym_pkg::xym_reg_t     ptr_r4,
	output xym_pkg::xym_reg_t     ptr_r5,
	output xym_pkg::xym_reg_t     ptr_r6,
	output xym_pkg::xym_reg_t     ptr_r7,
	output xym_pkg::xym_reg_t     x_operand_reg_0,
	output xym_pkg::xym_reg_t     x_operand_reg_1,
	output xym_pkg::xym_reg_t     y_operand_reg_0,
	output xym_pkg::xym_reg_t     y_operand_reg_1,
	output logic                  x_mem_req,
	output logic                  x_mem_we,
	output xym_pkg::xym_reg_t     x_mem_addr,
	output xym_pkg::xym_word_t    x_mem_wdata,
	output logic                  y_mem_req,
	output logic                  y_mem_we,
	output xym_pkg::xym_reg_t     y_mem_addr,
	output xym_pkg::xym_word_t    y_mem_wdata,
	output logic                  insn_done,
	output logic                  x_side_no_access,
	output logic                  y_side_no_access
);

	function automatic xym_pkg::xym_reg_t post_update(
		input xym_pkg::xym_reg_t  ptr,
		input xym_pkg::xym_mode_t mode,
		input xym_pkg::xym_reg_t  idx
	);
		xym_pkg::xym_reg_t res;
		res = ptr;
		unique case (mode)
			xym_pkg::XYM_MODE_NONE:  res = ptr;
			xym_pkg::XYM_MODE_KEEP:  res = ptr;
			xym_pkg::XYM_MODE_INC:   res = ptr + `XYM_PTR_STEP;
			xym_pkg::XYM_MODE_INDEX: res = ptr + idx;
		endcase
		return res;
	endfunction

	// Decode of the shared word
	logic               is_move;
	logic               x_ptr_sel, y_ptr_sel;
	logic               x_reg_sel, y_reg_sel;
	logic               x_store, y_store;
	xym_pkg::xym_mode_t x_mode, y_mode;
	logic               x_go, y_go;
	xym_pkg::xym_reg_t  x_ptr_val, y_ptr_val;
	xym_pkg::xym_reg_t  x_ptr_next, y_ptr_next;

	always_comb begin
		is_move   = insn_valid & (insn[`XYM_PREFIX_HI:`XYM_PREFIX_LO] == `XYM_PREFIX);
		// Interleaved fields: X takes bits 9, 7 and 5, Y bits 8, 6 and 4; the modes sit in 3:2 for X and 1:0 for Y
		x_ptr_sel = insn[`XYM_XPTR_BIT];
		y_ptr_sel = insn[`XYM_YPTR_BIT];
		x_reg_sel = insn[`XYM_XREG_BIT];
		y_reg_sel = insn[`XYM_YREG_BIT];
		x_store   = insn[`XYM_XDIR_BIT];
		y_store   = insn[`XYM_YDIR_BIT];
		x_mode    = xym_pkg::xym_mode_t'(insn[`XYM_XMODE_HI:`XYM_XMODE_LO]);
		y_mode    = xym_pkg::xym_mode_t'(insn[`XYM_YMODE_HI:`XYM_YMODE_LO]);
		// Mode 00 means no access, whatever the other side does
		x_go      = is_move & (x_mode != xym_pkg::XYM_MODE_NONE);
		y_go      = is_move & (y_mode != xym_pkg::XYM_MODE_NONE);
	end

	// Pointer registers
	xym_pkg::xym_reg_t r4_q, r4_d;
	xym_pkg::xym_reg_t r5_q, r5_d;
	xym_pkg::xym_reg_t r6_q, r6_d;
	xym_pkg::xym_reg_t r7_q, r7_d;

	always_comb begin
		x_ptr_val  = x_ptr_sel ? r5_q : r4_q;
		y_ptr_val  = y_ptr_sel ? r7_q : r6_q;
		// Access uses the old value, the update lands after it
		x_ptr_next = post_update(x_ptr_val, x_mode, x_index);
		y_ptr_next = post_update(y_ptr_val, y_mode, y_index);
		r4_d = r4_q;
		r5_d = r5_q;
		r6_d = r6_q;
		r7_d = r7_q;
		if (x_go) begin
			if (x_ptr_sel) begin
				r5_d = x_ptr_next;
			end else begin
				r4_d = x_ptr_next;
			end
		end
		if (y_go) begin
			if (y_ptr_sel) begin
				r7_d = y_ptr_next;
			end else begin
				r6_d = y_ptr_next;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r4_q <= `XYM_REG_RST;
			r5_q <= `XYM_REG_RST;
			r6_q <= `XYM_REG_RST;
			r7_q <= `XYM_REG_RST;
		end else if (ce) begin
			r4_q <= r4_d;
			r5_q <= r5_d;
			r6_q <= r6_d;
			r7_q <= r7_d;
		end
	end

	// Memory request stages, one per bus
	logic x_wb_valid, x_wb_sel;
	logic y_wb_valid, y_wb_sel;

	xym_mem_port u_x_port (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.issue     (x_go),
		.store     (x_store),
		.src_sel   (x_reg_sel),
		.dst_sel   (x_reg_sel),
		.ptr_val   (x_ptr_val),
		.acc_0     (accumulator_0),
		.acc_1     (accumulator_1),
		.mem_req   (x_mem_req),
		.mem_we    (x_mem_we),
		.mem_addr  (x_mem_addr),
		.mem_wdata (x_mem_wdata),
		.wb_valid  (x_wb_valid),
		.wb_sel    (x_wb_sel)
	);

	xym_mem_port u_y_port (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.issue     (y_go),
		.store     (y_store),
		.src_sel   (y_reg_sel),
		.dst_sel   (y_reg_sel),
		.ptr_val   (y_ptr_val),
		.acc_0     (accumulator_0),
		.acc_1     (accumulator_1),
		.mem_req   (y_mem_req),
		.mem_we    (y_mem_we),
		.mem_addr  (y_mem_addr),
		.mem_wdata (y_mem_wdata),
		.wb_valid  (y_wb_valid),
		.wb_sel    (y_wb_sel)
	);

	// Operand registers, written from the returning word
	xym_pkg::xym_reg_t x0_q, x0_d;
	xym_pkg::xym_reg_t x1_q, x1_d;
	xym_pkg::xym_reg_t y0_q, y0_d;
	xym_pkg::xym_reg_t y1_q, y1_d;

	always_comb begin
		x0_d = x0_q;
		x1_d = x1_q;
		y0_d = y0_q;
		y1_d = y1_q;
		if (x_wb_valid) begin
			if (x_wb_sel) begin
				x1_d = {x_mem_rdata, `XYM_LOWER_ZERO};
			end else begin
				x0_d = {x_mem_rdata, `XYM_LOWER_ZERO};
			end
		end
		if (y_wb_valid) begin
			if (y_wb_sel) begin
				y1_d = {y_mem_rdata, `XYM_LOWER_ZERO};
			end else begin
				y0_d = {y_mem_rdata, `XYM_LOWER_ZERO};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			x0_q <= `XYM_REG_RST;
			x1_q <= `XYM_REG_RST;
			y0_q <= `XYM_REG_RST;
			y1_q <= `XYM_REG_RST;
		end else if (ce) begin
			x0_q <= x0_d;
			x1_q <= x1_d;
			y0_q <= y0_d;
			y1_q <= y1_d;
		end
	end

	// Completion and no-access markers; the condition flag has no port here at all
	logic done_q, done_d;
	logic xna_q, xna_d;
	logic yna_q, yna_d;

	always_comb begin
		done_d = is_move;
		xna_d  = is_move & ~x_go;
		yna_d  = is_move & ~y_go;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			xna_q  <= 1'b0;
			yna_q  <= 1'b0;
		end else if (ce) begin
			done_q <= done_d;
			xna_q  <= xna_d;
			yna_q  <= yna_d;
		end
	end

	assign ptr_r4           = r4_q;
	assign ptr_r5           = r5_q;
	assign ptr_r6           = r6_q;
	assign ptr_r7           = r7_q;
	assign x_operand_reg_0  = x0_q;
	assign x_operand_reg_1  = x1_q;
	assign y_operand_reg_0  = y0_q;
	assign y_operand_reg_1  = y1_q;
	assign insn_done        = done_q;
	assign x_side_no_access = xna_q;
	assign y_side_no_access = yna_q;

endmodule

// >>> tb/xym_move_unit_sva.sv
`timescale 1ns/1ns
module xym_move_unit_sva (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               ce,
	input wire logic               insn_valid,
	input wire logic [15:0]        insn,
	input wire xym_pkg::xym_reg_t  x_index,
	input wire xym_pkg::xym_reg_t  accumulator_0,
	input wire xym_pkg::xym_reg_t  accumulator_1,
	input wire xym_pkg::xym_word_t x_mem_rdata,
	input wire xym_pkg::xym_reg_t  ptr_r4,
	input wire xym_pkg::xym_reg_t  ptr_r5,
	input wire xym_pkg::xym_reg_t  ptr_r6,
	input wire xym_pkg::xym_reg_t  x_operand_reg_0,
	input wire logic               x_mem_req,
	input wire logic               x_mem_we,
	input wire xym_pkg::xym_word_t x_mem_wdata,
	input wire xym_pkg::xym_reg_t  x_mem_addr,
	input wire logic               y_mem_req,
	input wire xym_pkg::xym_reg_t  y_mem_addr,
	input wire logic               insn_done,
	input wire logic               x_side_no_access,
	input wire logic               y_side_no_access
);
	logic        go;
	logic [15:0] xsrc;
	assign go = insn_valid && ce && insn[15:10] == 6'h3c;
	assign xsrc = insn[7] ? accumulator_1[31:16] : accumulator_0[31:16];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_done_pulse: assert property (go |=> insn_done) else $error("no done pulse");
	a_other_quiet: assert property (insn_valid && ce && insn[15:10] != 6'h3c |=> !insn_done && !x_mem_req && !y_mem_req)
		else $error("non-move word acted");
	a_x_noaccess: assert property (go && insn[3:2] == 2'h0 |=> x_side_no_access && !x_mem_req)
		else $error("x idle form accessed");
	a_y_noaccess: assert property (go && insn[1:0] == 2'h0 |=> y_side_no_access && !y_mem_req)
		else $error("y idle form accessed");
	a_x_store_word: assert property (go && insn[3:2] != 2'h0 && insn[5] |=> x_mem_req && x_mem_we && x_mem_wdata == $past(xsrc))
		else $error("bad x store");
	a_x_load_half: assert property (go && insn[3:2] != 2'h0 && !insn[5] && !insn[7] ##1 !insn_valid
		|-> ##2 x_operand_reg_0 == {$past(x_mem_rdata), 16'h0000}) else $error("bad x load");
	a_x_index_add: assert property (go && insn[3:2] == 2'h3 && !insn[9] |=> ptr_r4 == $past(ptr_r4) + $past(x_index))
		else $error("bad x index step");
	a_x_inc_two: assert property (go && insn[3:2] == 2'h2 && insn[9] |=> ptr_r5 == $past(ptr_r5) + 32'h2)
		else $error("bad x step");
	a_x_addr_old: assert property (go && insn[3:2] != 2'h0 && insn[9] |=> x_mem_addr == $past(ptr_r5))
		else $error("bad x address");
	a_y_addr_old: assert property (go && insn[1:0] != 2'h0 && !insn[8] |=> y_mem_addr == $past(ptr_r6))
		else $error("bad y address");
	a_y_keep_ptr: assert property (go && insn[1:0] == 2'h1 && !insn[8] |=> $stable(ptr_r6))
		else $error("y pointer moved");
endmodule

bind xym_move_unit xym_move_unit_sva u_sva (.clk, .rst_n, .ce, .insn_valid, .insn, .x_index, .accumulator_0,
	.accumulator_1, .x_mem_rdata, .ptr_r4, .ptr_r5, .ptr_r6, .x_operand_reg_0, .x_mem_req, .x_mem_we,
	.x_mem_wdata, .x_mem_addr, .y_mem_req, .y_mem_addr, .insn_done, .x_side_no_access, .y_side_no_access);

// >>> tb/xym_mem_model.sv
`timescale 1ns/1ns
module xym_mem_model #(parameter logic [15:0] SALT = 16'h0000) (
	input wire logic               clk,
	input wire logic               ce,
	input wire logic               req,
	input wire logic               we,
	input wire xym_pkg::xym_reg_t  addr,
	input wire xym_pkg::xym_word_t wdata,
	output xym_pkg::xym_word_t     rdata
);
	logic [15:0] mem [256];
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 16'(i) * 16'h0101 ^ SALT;
		rdata = 16'h5a5a;
	end
	// Word cells only; outside an answer the bus toggles so stale data never passes
	always @(posedge clk) if (ce) begin
		if (req && we) mem[addr[8:1]] <= wdata;
		rdata <= (req && !we) ? mem[addr[8:1]] : ~rdata;
	end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic                    clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic                    ce = 1'b1;
	logic                    insn_valid = 1'b0;
	logic [15:0]             insn = 16'h0000;
	logic [15:0]             w;
	xym_pkg::xym_reg_t       acc [2] = '{32'h0, 32'h0};
	xym_pkg::xym_reg_t       idx [2] = '{32'h0, 32'h0};
	wire xym_pkg::xym_word_t rd [2];
	wire [1:0]               reqv, wev, nav;
	wire                     done;
	wire xym_pkg::xym_reg_t  addrv [2], ptrv [4], opv [4];
	wire xym_pkg::xym_word_t wdv [2];
	xym_pkg::xym_reg_t       ptr [4], opr [4];
	logic [15:0]             sh [2][256];
	int                      error_cnt = 0;
	int                      total_checks = 0;
	int                      seed = 32'hd46a;

	always #25 clk = ~clk;

	xym_move_unit DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .insn_valid(insn_valid), .insn(insn),
		.x_index(idx[0]), .y_index(idx[1]), .accumulator_0(acc[0]), .accumulator_1(acc[1]),
		.x_mem_rdata(rd[0]), .y_mem_rdata(rd[1]), .ptr_r4(ptrv[0]), .ptr_r5(ptrv[1]), .ptr_r6(ptrv[2]),
		.ptr_r7(ptrv[3]), .x_operand_reg_0(opv[0]), .x_operand_reg_1(opv[1]), .y_operand_reg_0(opv[2]),
		.y_operand_reg_1(opv[3]), .x_mem_req(reqv[0]), .x_mem_we(wev[0]), .x_mem_addr(addrv[0]),
		.x_mem_wdata(wdv[0]), .y_mem_req(reqv[1]), .y_mem_we(wev[1]), .y_mem_addr(addrv[1]),
		.y_mem_wdata(wdv[1]), .insn_done(done), .x_side_no_access(nav[0]), .y_side_no_access(nav[1]));
	xym_mem_model #(.SALT(16'h0000)) u_xmem (.clk(clk), .ce(ce), .req(reqv[0]), .we(wev[0]),
		.addr(addrv[0]), .wdata(wdv[0]), .rdata(rd[0]));
	xym_mem_model #(.SALT(16'h0f0f)) u_ymem (.clk(clk), .ce(ce), .req(reqv[1]), .we(wev[1]),
		.addr(addrv[1]), .wdata(wdv[1]), .rdata(rd[1]));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Pointer after the access: keep, step by one word, or add the index
	function automatic xym_pkg::xym_reg_t exp_ptr(input xym_pkg::xym_reg_t p, input logic [1:0] md,
		input xym_pkg::xym_reg_t ix);
		return (md == 2'h1) ? p : (md == 2'h2) ? p + 32'h2 : p + ix;
	endfunction

	// One word, then idle until any load has landed in its operand register
	task automatic run(input logic [15:0] wd);
		logic [1:0]         m [2];
		logic               a [2], r [2], d [2], act [2];
		xym_pkg::xym_reg_t  old [2];
		logic [15:0]        ld [2];
		logic               mv;
		mv = wd[15:10] == 6'h3c;
		for (int s = 0; s < 2; s++) begin
			acc[s] = $random(seed);
			idx[s] = $random(seed);
			a[s] = wd[9 - s];
			r[s] = wd[7 - s];
			d[s] = wd[5 - s];
			m[s] = s ? wd[1:0] : wd[3:2];
			act[s] = mv && m[s] != 2'h0;
			old[s] = ptr[2 * s + a[s]];
		end
		insn = wd;
		insn_valid = 1'b1;
		@(posedge clk);
		#2;
		insn_valid = 1'b0;
		chk(done, mv);
		for (int s = 0; s < 2; s++) begin
			chk(reqv[s], act[s]);
			chk(nav[s], mv && !act[s]);
			if (act[s]) begin
				chk(addrv[s], old[s]);
				chk(wev[s], d[s]);
				ld[s] = sh[s][old[s][8:1]];
				if (d[s]) begin
					sh[s][old[s][8:1]] = acc[r[s]][31:16];
					chk(wdv[s], acc[r[s]][31:16]);
				end
				ptr[2 * s + a[s]] = exp_ptr(old[s], m[s], idx[s]);
			end
		end
		for (int k = 0; k < 4; k++) chk(ptrv[k], ptr[k]);
		repeat (2) @(posedge clk);
		#2;
		for (int s = 0; s < 2; s++) if (act[s] && !d[s]) opr[2 * s + r[s]] = {ld[s], 16'h0000};
		for (int k = 0; k < 4; k++) chk(opv[k], opr[k]);
	endtask

	initial begin
		for (int i = 0; i < 4; i++) begin
			ptr[i] = 32'h0;
			opr[i] = 32'h0;
		end
		for (int i = 0; i < 256; i++) begin
			sh[0][i] = 16'(i) * 16'h0101;
			sh[1][i] = 16'(i) * 16'h0101 ^ 16'h0f0f;
		end
		repeat (2) @(posedge clk);
		#2;
		rst_n = 1'b1;
		@(posedge clk);
		#2;
		for (int i = 0; i < 64; i++) run({6'h3c, i[0], i[1], i[2], i[3], i[4], i[5], i[5:2]});
		$display("test all_modes done");
		for (int i = 0; i < 200; i++) begin
			w = $random(seed);
			if (w[11]) w[15:10] = 6'h3c;
			run(w);
		end
		$display("test random_words done");
		// A move offered while the enable is low must leave no trace
		ce = 1'b0;
		insn = 16'hf08a;
		insn_valid = 1'b1;
		@(posedge clk);
		#2;
		insn_valid = 1'b0;
		ce = 1'b1;
		chk(done, 1'b0);
		chk(reqv, 2'h0);
		for (int k = 0; k < 4; k++) chk(ptrv[k], ptr[k]);
		repeat (2) @(posedge clk);
		#2;
		for (int k = 0; k < 4; k++) chk(opv[k], opr[k]);
		$display("test ce_freeze done");
		wrap_up();
	end

	initial begin
		#500000;
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule
